/* verilog/dcd_map.svh */
`ifndef DCD_MAP_SVH
`define DCD_MAP_SVH

// ==========================================================
// command codes
`define DCD_CMD_ERASE 8'h14
`define DCD_CMD_WR_CFG 8'h1d
`define DCD_CMD_RD_CFG 8'h24
`define DCD_CMD_PC_READ 8'h28
`define DCD_CMD_STATUS 8'h34
`define DCD_CMD_BP_SET 8'h3b
`define DCD_CMD_HALT 8'h44
`define DCD_CMD_RESUME 8'h4c
`define DCD_CMD_STEP 8'h5c
`define DCD_CMD_ID 8'h68
// upper six bits of the run and step-replace codes
`define DCD_CMD_RUN_HI 6'h15
`define DCD_CMD_REPL_HI 6'h19

// ==========================================================
// field positions, reset values and argument byte counts
`define DCD_CFG_RESET 8'h00
`define DCD_CFG_DMA_PAUSE 2
`define DCD_BP_SEL_HI 4
`define DCD_BP_SEL_LO 3
`define DCD_BP_EN 2
`define DCD_BP_ARGS 2'h3
`define DCD_WR_CFG_ARGS 2'h1

// ==========================================================
// link timing: index of the last bit in a byte
`define DCD_BYTE_LAST 3'h7

`endif

/* verilog/dcd_pkg.sv */
package dcd_pkg;

    // ==========================================================
    // decoder states, gray along idle-args-exec-reply
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_args = 2'b01,
        st_exec = 2'b11,
        st_reply = 2'b10
    } dcd_state_t;

endpackage : dcd_pkg

/* verilog/dcd_link_if.sv */
`timescale 1ns/100ps
interface dcd_link_if;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic tx_load;
    logic [7:0] tx_byte;
    logic tx_done;

    modport link (
        output rx_valid,
        output rx_byte,
        output tx_done,
        input tx_load,
        input tx_byte
    );
    modport ctrl (
        input rx_valid,
        input rx_byte,
        input tx_done,
        output tx_load,
        output tx_byte
    );
endinterface : dcd_link_if

/* verilog/dcd_link.sv */
`timescale 1ns/100ps
`include "dcd_map.svh"
module dcd_link (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // debug pins
    input wire logic dbg_clk_pin,
    input wire logic dbg_data_pin,
    output logic dbg_data_out,
    output logic dbg_data_oe,
    // byte side
    dcd_link_if.link lnk
);
    logic clk_s1, clk_s2, clk_s3;
    logic dat_s1, dat_s2;
    logic rise, fall;
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    logic [7:0] tx_sh;
    logic [2:0] tx_cnt;
    logic tx_act;

    // ==========================================================
    // pin synchronisers
    always_ff @(posedge clk) begin
        if (reset) begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
            dat_s1 <= 1'b0;
            dat_s2 <= 1'b0;
        end else begin
            clk_s1 <= dbg_clk_pin;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            dat_s1 <= dbg_data_pin;
            dat_s2 <= dat_s1;
        end
    end

    assign rise = clk_s2 & ~clk_s3;
    assign fall = ~clk_s2 & clk_s3;

    // ==========================================================
    // receive: sample on falling edge, msb first
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_sh <= 8'h00;
            rx_cnt <= 3'h0;
            lnk.rx_valid <= 1'b0;
            lnk.rx_byte <= 8'h00;
        end else begin
            lnk.rx_valid <= 1'b0;
            if (fall && !tx_act) begin
                rx_sh <= {rx_sh[6:0], dat_s2};
                rx_cnt <= rx_cnt + 3'h1;
                if (rx_cnt == `DCD_BYTE_LAST) begin
                    lnk.rx_valid <= 1'b1;
                    lnk.rx_byte <= {rx_sh[6:0], dat_s2};
                end
            end
        end
    end

    // ==========================================================
    // transmit: drive on rising edge, msb first
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_sh <= 8'h00;
            tx_cnt <= 3'h0;
            tx_act <= 1'b0;
            dbg_data_out <= 1'b0;
            dbg_data_oe <= 1'b0;
            lnk.tx_done <= 1'b0;
        end else begin
            lnk.tx_done <= 1'b0;
            if (lnk.tx_load) begin
                tx_sh <= lnk.tx_byte;
                tx_cnt <= 3'h0;
                tx_act <= 1'b1;
            end else if (tx_act && rise) begin
                dbg_data_out <= tx_sh[7];
                dbg_data_oe <= 1'b1;
                tx_sh <= {tx_sh[6:0], 1'b0};
            end else if (tx_act && fall) begin
                tx_cnt <= tx_cnt + 3'h1;
                if (tx_cnt == `DCD_BYTE_LAST) begin
                    tx_act <= 1'b0;
                    dbg_data_oe <= 1'b0;
                    lnk.tx_done <= 1'b1;
                end
            end
        end
    end

    a_rx_on_fall:
        assert property (@(posedge clk) disable iff (reset)
            lnk.rx_valid |-> $past(fall) && !$past(tx_act))
        else $error("byte received without falling edge");

endmodule : dcd_link

/* verilog/dcd_decoder.sv */
`timescale 1ns/100ps
`include "dcd_map.svh"
module dcd_decoder #(
    // arbitrary identification values
    parameter logic [7:0] PART_NUM = 8'h5a,
    parameter logic [7:0] VERSION = 8'h01
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // debug link pins
    input wire logic dbg_clk_pin,
    input wire logic dbg_data_pin,
    output logic dbg_data_out,
    output logic dbg_data_oe,
    // cpu status
    input wire logic [15:0] cpu_code_addr,
    input wire logic [15:0] cpu_pc,
    input wire logic cpu_halted,
    input wire logic cpu_op_done,
    input wire logic cpu_idle,
    input wire logic power_mode0,
    input wire logic osc_stable,
    // cpu control
    output logic cpu_halt,
    output logic cpu_step,
    output logic cpu_instr_run,
    output logic cpu_step_replace,
    output logic [1:0] cpu_instr_len,
    output logic [23:0] cpu_instr,
    // flash
    input wire logic erase_done,
    input wire logic debug_lock_bit,
    output logic erase_start,
    // configuration
    output logic [7:0] debug_config,
    output logic dma_pause
);
    dcd_link_if lnk ();
    dcd_pkg::dcd_state_t state;
    logic [7:0] cmd;
    logic [23:0] args;
    logic [1:0] need;
    logic waiting;
    logic tx_load;
    logic [7:0] tx_byte;
    logic [7:0] reply_lo;
    logic reply_two;
    logic locked;
    logic lock_loaded;
    logic halt_cause;
    logic [3:0] bp_en;
    logic [15:0] bp_addr [4];
    logic [3:0] bp_match;
    logic bp_hit;
    logic act;
    logic is_run, is_repl, cpu_cmd;
    logic [2:0] rx_dec;
    logic [7:0] status;

    dcd_link u_link (
        .clk(clk),
        .reset(reset),
        .dbg_clk_pin(dbg_clk_pin),
        .dbg_data_pin(dbg_data_pin),
        .dbg_data_out(dbg_data_out),
        .dbg_data_oe(dbg_data_oe),
        .lnk(lnk.link)
    );
    assign lnk.tx_load = tx_load;
    assign lnk.tx_byte = tx_byte;

    // ==========================================================
    // command decode: {accepted, data bytes to follow}
    function automatic logic [2:0] decode(input logic [7:0] c, input logic lk);
        logic [2:0] r;
        r = 3'h0;
        unique case (c)
            `DCD_CMD_ERASE, `DCD_CMD_STATUS, `DCD_CMD_ID: r = 3'h4;
            `DCD_CMD_WR_CFG: r = {1'b1, `DCD_WR_CFG_ARGS};
            `DCD_CMD_BP_SET: r = {1'b1, `DCD_BP_ARGS};
            `DCD_CMD_RD_CFG, `DCD_CMD_PC_READ, `DCD_CMD_HALT,
            `DCD_CMD_RESUME, `DCD_CMD_STEP: r = 3'h4;
            default: begin
                if ((c[7:2] == `DCD_CMD_RUN_HI || c[7:2] == `DCD_CMD_REPL_HI)
                        && c[1:0] != 2'h0)
                    r = {1'b1, c[1:0]};
            end
        endcase
        if (lk && c != `DCD_CMD_ERASE && c != `DCD_CMD_STATUS && c != `DCD_CMD_ID)
            r = 3'h0;
        return r;
    endfunction : decode

    assign rx_dec = decode(lnk.rx_byte, locked);
    assign act = (state == dcd_pkg::st_exec) && !waiting;
    assign is_run = cmd[7:2] == `DCD_CMD_RUN_HI;
    assign is_repl = cmd[7:2] == `DCD_CMD_REPL_HI;
    assign cpu_cmd = is_run || is_repl || cmd == `DCD_CMD_STEP;
    assign status = {erase_done, cpu_idle, cpu_halted, power_mode0,
                     halt_cause, locked, osc_stable, 1'b0};

    // ==========================================================
    // command sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= dcd_pkg::st_idle;
            cmd <= 8'h00;
            args <= 24'h000000;
            need <= 2'h0;
            waiting <= 1'b0;
            tx_load <= 1'b0;
            tx_byte <= 8'h00;
            reply_lo <= 8'h00;
            reply_two <= 1'b0;
        end else begin
            tx_load <= 1'b0;
            unique case (state)
                dcd_pkg::st_idle: begin
                    if (lnk.rx_valid && rx_dec[2]) begin
                        cmd <= lnk.rx_byte;
                        need <= rx_dec[1:0];
                        state <= (rx_dec[1:0] == 2'h0) ? dcd_pkg::st_exec
                                                       : dcd_pkg::st_args;
                    end
                end
                dcd_pkg::st_args: begin
                    if (lnk.rx_valid) begin
                        args <= {args[15:0], lnk.rx_byte};
                        need <= need - 2'h1;
                        if (need == 2'h1)
                            state <= dcd_pkg::st_exec;
                    end
                end
                dcd_pkg::st_exec: begin
                    if (!waiting && cpu_cmd) begin
                        waiting <= 1'b1;
                    end else if (!waiting || cpu_op_done) begin
                        waiting <= 1'b0;
                        state <= dcd_pkg::st_reply;
                        tx_load <= 1'b1;
                        reply_two <= 1'b0;
                        unique case (cmd)
                            `DCD_CMD_RD_CFG: tx_byte <= debug_config;
                            `DCD_CMD_PC_READ: begin
                                tx_byte <= cpu_pc[15:8];
                                reply_lo <= cpu_pc[7:0];
                                reply_two <= 1'b1;
                            end
                            `DCD_CMD_ID: begin
                                tx_byte <= PART_NUM;
                                reply_lo <= VERSION;
                                reply_two <= 1'b1;
                            end
                            default: tx_byte <= status;
                        endcase
                    end
                end
                dcd_pkg::st_reply: begin
                    if (lnk.tx_done) begin
                        if (reply_two) begin
                            tx_load <= 1'b1;
                            tx_byte <= reply_lo;
                            reply_two <= 1'b0;
                        end else begin
                            state <= dcd_pkg::st_idle;
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // cpu instruction strobes
    always_ff @(posedge clk) begin
        if (reset) begin
            cpu_step <= 1'b0;
            cpu_instr_run <= 1'b0;
            cpu_step_replace <= 1'b0;
            cpu_instr_len <= 2'h0;
            cpu_instr <= 24'h000000;
        end else begin
            cpu_step <= act && cmd == `DCD_CMD_STEP;
            cpu_instr_run <= act && is_run;
            cpu_step_replace <= act && is_repl;
            if (act && (is_run || is_repl)) begin
                cpu_instr_len <= cmd[1:0];
                cpu_instr <= args;
            end
        end
    end

    // ==========================================================
    // breakpoints
    always_comb begin
        for (int i = 0; i < 4; i++)
            bp_match[i] = bp_en[i] && bp_addr[i] == cpu_code_addr;
    end
    assign bp_hit = |bp_match && !cpu_halt;

    always_ff @(posedge clk) begin
        if (reset) begin
            bp_en <= 4'h0;
            for (int i = 0; i < 4; i++)
                bp_addr[i] <= 16'h0000;
        end else if (act && cmd == `DCD_CMD_BP_SET) begin
            bp_en[args[16+`DCD_BP_SEL_HI:16+`DCD_BP_SEL_LO]] <= args[16+`DCD_BP_EN];
            bp_addr[args[16+`DCD_BP_SEL_HI:16+`DCD_BP_SEL_LO]] <= args[15:0];
        end
    end

    // ==========================================================
    // halt control
    always_ff @(posedge clk) begin
        if (reset) begin
            cpu_halt <= 1'b0;
            halt_cause <= 1'b0;
        end else if (act && cmd == `DCD_CMD_HALT) begin
            cpu_halt <= 1'b1;
            halt_cause <= 1'b0;
        end else if (act && cmd == `DCD_CMD_RESUME) begin
            cpu_halt <= 1'b0;
        end else if (bp_hit) begin
            cpu_halt <= 1'b1;
            halt_cause <= 1'b1;
        end
    end

    // ==========================================================
    // lock, erase and configuration
    always_ff @(posedge clk) begin
        if (reset) begin
            locked <= 1'b0;
            lock_loaded <= 1'b0;
        end else if (!lock_loaded) begin
            locked <= ~debug_lock_bit;
            lock_loaded <= 1'b1;
        end else if (act && cmd == `DCD_CMD_ERASE) begin
            locked <= 1'b0;
        end else if (act && (cpu_cmd || cmd == `DCD_CMD_HALT
                             || cmd == `DCD_CMD_RESUME)) begin
            locked <= ~debug_lock_bit;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            erase_start <= 1'b0;
            debug_config <= `DCD_CFG_RESET;
            dma_pause <= 1'b0;
        end else begin
            erase_start <= act && cmd == `DCD_CMD_ERASE;
            if (act && cmd == `DCD_CMD_WR_CFG) begin
                debug_config <= args[7:0];
                dma_pause <= args[`DCD_CFG_DMA_PAUSE];
            end
        end
    end

    // ==========================================================
    // checks
    a_erase_start:
        assert property (@(posedge clk) disable iff (reset)
            act && cmd == `DCD_CMD_ERASE |=> erase_start && !locked ##1 !erase_start)
        else $error("erase not started or lock kept");
    a_cfg_store:
        assert property (@(posedge clk) disable iff (reset)
            act && cmd == `DCD_CMD_WR_CFG |=> debug_config == $past(args[7:0]))
        else $error("configuration byte not stored");
    a_dma_pause:
        assert property (@(posedge clk) disable iff (reset)
            dma_pause == debug_config[`DCD_CFG_DMA_PAUSE])
        else $error("dma pause differs from configuration");
    a_bp_halt:
        assert property (@(posedge clk) disable iff (reset)
            bp_hit && !act |=> cpu_halt && halt_cause)
        else $error("breakpoint match did not halt");
    a_halt_cmd:
        assert property (@(posedge clk) disable iff (reset)
            act && cmd == `DCD_CMD_HALT |=> cpu_halt && !halt_cause && tx_load)
        else $error("halt command not obeyed");
    a_resume_cmd:
        assert property (@(posedge clk) disable iff (reset)
            act && cmd == `DCD_CMD_RESUME |=> !cpu_halt)
        else $error("resume did not release cpu");
    a_run_strobe:
        assert property (@(posedge clk) disable iff (reset)
            act && is_run |=> cpu_instr_run && cpu_instr_len == $past(cmd[1:0])
                && !cpu_step_replace)
        else $error("run strobe wrong");
    a_lock_ignore:
        assert property (@(posedge clk) disable iff (reset)
            state == dcd_pkg::st_idle && lnk.rx_valid && locked
            && lnk.rx_byte == `DCD_CMD_HALT |=> state == dcd_pkg::st_idle)
        else $error("locked decoder accepted command");
    a_unknown_cmd:
        assert property (@(posedge clk) disable iff (reset)
            state == dcd_pkg::st_idle && lnk.rx_valid && !rx_dec[2]
            |=> state == dcd_pkg::st_idle && $stable(cmd))
        else $error("unknown command changed state");
    a_bp_args:
        assert property (@(posedge clk) disable iff (reset)
            state == dcd_pkg::st_idle && lnk.rx_valid
            && rx_dec == {1'b1, `DCD_BP_ARGS} |=> need == `DCD_BP_ARGS)
        else $error("breakpoint argument count wrong");

endmodule : dcd_decoder

/* dv/dcd_host.sv */
`timescale 1ns/100ps
module dcd_host (
    // device side of the data wire
    input wire logic dev_out,
    input wire logic dev_oe,
    // link pins
    output logic link_clk,
    output logic link_data
);
    logic host_drv;

    // ==========================================================
    // resolved wire: device wins while it drives
    assign link_data = dev_oe ? dev_out : host_drv;

    initial begin
        link_clk = 1'b0;
        host_drv = 1'b1;
    end

    // ==========================================================
    // one byte out, msb first, changed at the rising edge
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            link_clk = 1'b1;
            host_drv = b[i];
            #160;
            link_clk = 1'b0;
            #160;
        end
    endtask : send_byte

    // one byte in, sampled at the falling edge
    task automatic recv_byte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            link_clk = 1'b1;
            // released wire shows no stale level
            host_drv = ~host_drv;
            #160;
            link_clk = 1'b0;
            b[i] = link_data;
            #160;
        end
    endtask : recv_byte
endmodule : dcd_host

/* dv/dcd_decoder_test.sv */
`timescale 1ns/100ps
module dcd_decoder_test;
    // arbitrary identification values
    localparam logic [7:0] TB_PART = 8'h3c;
    localparam logic [7:0] TB_VER = 8'h07;
    logic clk = 1'b0, reset = 1'b1, dbg_clk_pin, dbg_data_pin, dbg_data_out, dbg_data_oe;
    logic [15:0] cpu_code_addr = 16'h0000, cpu_pc = 16'h0000;
    logic cpu_halted, cpu_op_done, cpu_idle = 1'b0, power_mode0 = 1'b1, osc_stable = 1'b1;
    logic cpu_halt, cpu_step, cpu_instr_run, cpu_step_replace, erase_start, dma_pause;
    logic [1:0] cpu_instr_len, got_len;
    logic [23:0] cpu_instr, got_instr, m;
    logic erase_done, debug_lock_bit = 1'b1, hc = 1'b0, lk = 1'b0, ed_s, ch_s;
    logic [7:0] debug_config, cfg;
    logic [15:0] rx, a;
    int n_mismatch = 0, n_tests = 0, n_done, n_run, n_step, n_repl, n_erase, dly, ecnt, d, r0;

    always #20 clk = ~clk;

    dcd_host host (.dev_out(dbg_data_out), .dev_oe(dbg_data_oe), .link_clk(dbg_clk_pin),
        .link_data(dbg_data_pin));

    dcd_decoder #(.PART_NUM(TB_PART), .VERSION(TB_VER)) dut (.clk(clk), .reset(reset),
        .dbg_clk_pin(dbg_clk_pin), .dbg_data_pin(dbg_data_pin), .dbg_data_out(dbg_data_out),
        .dbg_data_oe(dbg_data_oe), .cpu_code_addr(cpu_code_addr), .cpu_pc(cpu_pc),
        .cpu_halted(cpu_halted), .cpu_op_done(cpu_op_done), .cpu_idle(cpu_idle),
        .power_mode0(power_mode0), .osc_stable(osc_stable), .cpu_halt(cpu_halt),
        .cpu_step(cpu_step), .cpu_instr_run(cpu_instr_run), .cpu_step_replace(cpu_step_replace),
        .cpu_instr_len(cpu_instr_len), .cpu_instr(cpu_instr), .erase_done(erase_done),
        .debug_lock_bit(debug_lock_bit), .erase_start(erase_start),
        .debug_config(debug_config), .dma_pause(dma_pause));

    // ==========================================================
    // cpu and flash stand-ins, pulse capture
    always @(posedge clk) begin
        if (reset) begin
            {cpu_halted, cpu_op_done, erase_done} <= 3'b001;
            {dly, ecnt, n_done, n_run, n_step, n_repl, n_erase} <= '0;
        end else begin
            cpu_halted <= cpu_halt;
            cpu_op_done <= (dly == 1);
            dly <= (cpu_step | cpu_instr_run | cpu_step_replace) ? 5 : (dly != 0 ? dly - 1 : 0);
            ecnt <= erase_start ? 300 : (ecnt != 0 ? ecnt - 1 : 0);
            erase_done <= erase_start ? 1'b0 : (ecnt == 1 ? 1'b1 : erase_done);
            n_done <= n_done + int'(cpu_op_done);
            n_run <= n_run + int'(cpu_instr_run);
            n_step <= n_step + int'(cpu_step);
            n_repl <= n_repl + int'(cpu_step_replace);
            n_erase <= n_erase + int'(erase_start);
            if (cpu_instr_run | cpu_step_replace) begin
                got_len <= cpu_instr_len;
                got_instr <= cpu_instr;
            end
        end
    end

    // ==========================================================
    // helpers
    function automatic logic [7:0] exp_status();
        return {ed_s, cpu_idle, ch_s, power_mode0, hc, lk, osc_stable, 1'b0};
    endfunction : exp_status

    task automatic end_of_test;
        if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // host bytes from the top of tx, then nr reply bytes
    task automatic cmd(input logic [31:0] tx, input int nb, input int nr, input bit cpu);
        int n0;
        logic [7:0] b;
        @(posedge clk);
        #1;
        n0 = n_done;
        rx = 16'h0000;
        for (int i = 0; i < nb; i++) host.send_byte(tx[31-8*i -: 8]);
        // stand-in levels as the decoder latches its status reply
        {ed_s, ch_s} = {erase_done, cpu_halted};
        if (cpu) begin
            for (int k = 0; k < 400 && n_done == n0; k++) @(posedge clk);
            if (n_done == n0) begin
                $display("mismatch cpu_op_done expected 1 seen 0");
                n_mismatch++;
                end_of_test();
            end
        end
        repeat (8) @(posedge clk);
        #1;
        for (int i = 0; i < nr; i++) begin
            host.recv_byte(b);
            rx = {rx[7:0], b};
        end
    endtask : cmd

    // ==========================================================
    // main sequence
    initial begin
        d = $urandom(39261);
        repeat (4) @(posedge clk);
        #1;
        reset = 1'b0;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            {cpu_idle, power_mode0, osc_stable} = 3'($urandom);
            cmd(32'h34000000, 1, 1, 0);
            chk("status", 24'(exp_status()), 24'(rx[7:0]));
        end
        osc_stable = 1'b1;
        for (int i = 0; i < 3; i++) begin
            cfg = 8'($urandom);
            cfg[2] = i[0];
            cmd({8'h1d, cfg, 16'h0000}, 2, 1, 0);
            chk("wr_status", 24'(exp_status()), 24'(rx[7:0]));
            chk("debug_config", 24'(cfg), 24'(debug_config));
            chk("dma_pause", 24'(cfg[2]), 24'(dma_pause));
            cmd(32'h24000000, 1, 1, 0);
            chk("rd_config", 24'(cfg), 24'(rx[7:0]));
        end
        cpu_pc = 16'($urandom);
        cmd(32'h28000000, 1, 2, 0);
        chk("pc", 24'(cpu_pc), 24'(rx));
        cmd(32'h68000000, 1, 2, 0);
        chk("id", 24'({TB_PART, TB_VER}), 24'(rx));
        r0 = n_run + n_repl + n_step + n_erase;
        cmd(32'hff000000, 1, 0, 0);
        cmd(32'h54000000, 1, 0, 0);
        chk("refused", 24'(r0), 24'(n_run + n_repl + n_step + n_erase));
        cmd(32'h34000000, 1, 1, 0);
        chk("after_unknown", 24'(exp_status()), 24'(rx[7:0]));
        cmd(32'h44000000, 1, 1, 0);
        chk("halt", 24'h1, 24'(cpu_halt));
        cmd(32'h34000000, 1, 1, 0);
        chk("halt_status", 24'(exp_status()), 24'(rx[7:0]));
        for (int L = 1; L <= 3; L++) begin
            for (int s = 0; s < 2; s++) begin
                d = $urandom;
                r0 = s ? n_repl : n_run;
                m = 24'((1 << (8 * L)) - 1);
                cmd({(s ? 8'h64 : 8'h54) | 8'(L), d[23:0]}, L + 1, 1, 1);
                chk("instr_pulse", 24'(r0 + 1), 24'(s ? n_repl : n_run));
                chk("instr_len", 24'(L), 24'(got_len));
                chk("instr", (d[23:0] >> (8 * (3 - L))) & m, got_instr & m);
            end
        end
        r0 = n_step;
        cmd(32'h5c000000, 1, 1, 1);
        chk("step", 24'(r0 + 1), 24'(n_step));
        hc = 1'b1;
        for (int en = 1; en >= 0; en--) begin
            // same slot twice: the second pass disables the first
            if (en == 1) d = $urandom;
            a = 16'($urandom);
            cmd({8'h3b, d[7:5], d[4:3], en[0], 2'b00, a}, 4, 1, 0);
            cpu_code_addr = ~a;
            cmd(32'h4c000000, 1, 1, 0);
            chk("resume", 24'h0, 24'(cpu_halt));
            repeat (4) @(posedge clk);
            #1;
            chk("bp_miss", 24'h0, 24'(cpu_halt));
            cpu_code_addr = a;
            for (int k = 0; k < 10 && cpu_halt !== 1'b1; k++) begin
                @(posedge clk);
                #1;
            end
            chk("bp_hit", 24'(en), 24'(cpu_halt));
            cmd(32'h34000000, 1, 1, 0);
            chk("bp_cause", 24'(exp_status()), 24'(rx[7:0]));
        end
        hc = 1'b0;
        cmd(32'h44000000, 1, 1, 0);
        cmd(32'h34000000, 1, 1, 0);
        chk("halt_cause", 24'(exp_status()), 24'(rx[7:0]));
        debug_lock_bit = 1'b0;
        cfg = debug_config;
        cmd(32'h44000000, 1, 1, 0);
        lk = 1'b1;
        cmd(32'h34000000, 1, 1, 0);
        chk("locked", 24'(exp_status()), 24'(rx[7:0]));
        cmd(32'h1dff0000, 2, 0, 0);
        chk("locked_cfg", 24'(cfg), 24'(debug_config));
        r0 = n_erase;
        cmd(32'h14000000, 1, 1, 0);
        chk("erase", 24'(r0 + 1), 24'(n_erase));
        debug_lock_bit = 1'b1;
        lk = 1'b0;
        for (int k = 0; k < 10; k++) begin
            cmd(32'h34000000, 1, 1, 0);
            chk("erase_status", 24'(exp_status()), 24'(rx[7:0]));
            if (rx[7] === 1'b1) break;
        end
        chk("erase_end", 24'h1, 24'(rx[7]));
        cmd(32'h1d5a0000, 2, 1, 0);
        chk("unlocked_cfg", 24'h5a, 24'(debug_config));
        end_of_test();
    end
endmodule : dcd_decoder_test
